//--- core/agu_top.sv
// Purpose: RAM operand and program counter address generation
// Assumes: the core presents one decoded instruction per step handshake
// Notes: table reference stalls the step port for one cycle
//
// Local design decision: the address-and-strobe port.
`include "agu_params.svh"
`timescale 1ns/1ps
`default_nettype none

module agu_top #(
    parameter int WORD_W = 10,
    parameter int PC_W = 14,
    parameter int RAM_W = 10
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_b,
    // instruction step from the decoder
    input wire logic stepValid,
    output logic stepReady,
    input wire agu_pkg::agu_op_t stepOp,
    input wire logic [WORD_W-1:0] stepWordOne,
    input wire logic [WORD_W-1:0] stepWordTwo,
    // operand sources
    input wire logic [3:0] accIn,
    input wire logic [3:0] bIn,
    input wire logic [1:0] wordIdx,
    input wire logic [3:0] colIdx,
    input wire logic [3:0] rowIdx,
    // program counter
    output logic [PC_W-1:0] programCounter,
    output logic [PC_W-1:0] returnAddr,
    output logic callPush,
    // RAM operand address
    output logic [RAM_W-1:0] ramAddr,
    output logic [3:0] ramBank,
    output logic ramStrobe,
    output logic ramSwap,
    // table ROM read port, data in the same cycle as the request
    output logic [PC_W-1:0] tableAddr,
    output logic tableRead,
    input wire logic [WORD_W-1:0] tableData,
    // table-reference destinations
    output logic [3:0] accOut,
    output logic [3:0] bOut,
    output logic accLoad,
    output logic [3:0] portLatchOne,
    output logic [3:0] portLatchTwo,
    output logic portLoad,
    // register port
    input wire logic [RAM_W-1:0] regAddr,
    input wire logic [3:0] regWrData,
    input wire logic regWr,
    input wire logic regRd,
    output logic [3:0] regRdData
);

    // state
    agu_pkg::agu_state_t state_r;
    agu_pkg::agu_state_t state_nxt;
    logic [PC_W-1:0] pc_r; // address of the next instruction
    logic [PC_W-1:0] pc_nxt;
    logic [3:0] bank_r; // ram_bank_select
    logic [RAM_W-1:0] ramAddr_r;
    logic [RAM_W-1:0] ramAddr_nxt;
    logic [3:0] ramBank_r;
    logic ramStrobe_r;
    logic ramSwap_r;
    logic [PC_W-1:0] retAddr_r;
    logic callPush_r;
    logic [PC_W-1:0] tableAddr_r;
    logic tableRead_r;
    logic [3:0] rdData_r;

    // decode helpers
    logic stepFire; // a step is taken this cycle
    logic twoWord; // instruction occupies two program words
    logic ramOp; // instruction addresses RAM
    logic [PC_W-1:0] pcPlusOne;
    logic [PC_W-1:0] pcSeq;
    logic [PC_W-1:0] longImm;
    logic [PC_W-1:0] tableTarget;
    logic inBankWin;

    // handshake: stall only while table data is awaited
    assign stepReady = (state_r == agu_pkg::AGU_IDLE);
    assign stepFire = stepValid && stepReady;

    // two-word forms carry their immediate in the second word
    always_comb begin
        case (stepOp)
            agu_pkg::AGU_OP_LONG_JUMP,
            agu_pkg::AGU_OP_LONG_BRANCH,
            agu_pkg::AGU_OP_CALL,
            agu_pkg::AGU_OP_RAM_DIR: begin
                twoWord = 1'b1; // RL4
            end
            default: begin
                twoWord = 1'b0;
            end
        endcase
    end

    // sequential advance, carry ripples into the page bits
    assign pcPlusOne = pc_r + 1'b1; // RL15
    assign pcSeq = twoWord ? pc_r + 2'd2 : pcPlusOne; // RL15

    // fourteen-bit immediate: four bits of word one, ten of word two
    assign longImm = {stepWordOne[3:0], stepWordTwo}; // RL6

    // table address: page top bits zero, then immediate, acc, B
    assign tableTarget = {2'b00, stepWordOne[3:0], accIn, bIn}; // RL11

    // program counter next value
    always_comb begin
        pc_nxt = pc_r;
        if (stepFire) begin
            case (stepOp)
                agu_pkg::AGU_OP_LONG_JUMP,
                agu_pkg::AGU_OP_LONG_BRANCH,
                agu_pkg::AGU_OP_CALL: begin
                    pc_nxt = longImm; // RL6
                end
                agu_pkg::AGU_OP_IN_PAGE: begin
                    // page taken from the already-advanced counter, so a
                    // jump at the last word of a page lands one page on
                    pc_nxt = {pcPlusOne[PC_W-1:`AGU_PAGE_BITS],
                              stepWordOne[7:0]}; // RL8 RL9 RL7
                end
                agu_pkg::AGU_OP_ZERO_CALL: begin
                    pc_nxt = {8'h00, stepWordOne[5:0]}; // RL10
                end
                agu_pkg::AGU_OP_TABLE_JUMP: begin
                    pc_nxt = tableTarget; // RL11
                end
                agu_pkg::AGU_OP_TABLE_REF: begin
                    pc_nxt = pcSeq; // RL14
                end
                default: begin
                    pc_nxt = pcSeq; // RL15
                end
            endcase
        end
    end

    // program counter register
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            pc_r <= `AGU_RST_PC;
        end else begin
            pc_r <= pc_nxt;
        end
    end

    // return address for the core's stack on both call forms
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            retAddr_r <= `AGU_RST_PC;
            callPush_r <= 1'b0;
        end else begin
            callPush_r <= stepFire && (stepOp == agu_pkg::AGU_OP_CALL ||
                                       stepOp == agu_pkg::AGU_OP_ZERO_CALL);
            if (stepFire) begin
                retAddr_r <= pcSeq;
            end
        end
    end

    // RAM address selection
    always_comb begin
        ramAddr_nxt = ramAddr_r;
        ramOp = 1'b0;
        case (stepOp)
            agu_pkg::AGU_OP_RAM_IND: begin
                ramAddr_nxt = {wordIdx, colIdx, rowIdx}; // RL2
                ramOp = 1'b1;
            end
            agu_pkg::AGU_OP_RAM_DIR: begin
                ramAddr_nxt = stepWordTwo; // RL4
                ramOp = 1'b1;
            end
            agu_pkg::AGU_OP_SCR_LOAD,
            agu_pkg::AGU_OP_SCR_SWAP: begin
                ramAddr_nxt = {`AGU_SCR_BASE, stepWordOne[3:0]}; // RL5
                ramOp = 1'b1;
            end
            default: begin
                ramOp = 1'b0;
            end
        endcase
    end

    // banked window check on the address about to be issued
    assign inBankWin = (ramAddr_nxt >= `AGU_BANK_LO) &&
                       (ramAddr_nxt <= `AGU_BANK_HI); // RL3

    // RAM address, bank and strobe; outside the window bank 0 is used
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            ramAddr_r <= '0;
            ramBank_r <= 4'h0;
            ramStrobe_r <= 1'b0;
            ramSwap_r <= 1'b0;
        end else begin
            ramStrobe_r <= stepFire && ramOp;
            ramSwap_r <= stepFire && (stepOp == agu_pkg::AGU_OP_SCR_SWAP);
            if (stepFire && ramOp) begin
                ramAddr_r <= ramAddr_nxt;
                ramBank_r <= inBankWin ? bank_r : 4'h0; // RL3
            end
        end
    end

    // table-reference sequencer: request, then capture the returned word
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            agu_pkg::AGU_IDLE: begin
                if (stepFire && stepOp == agu_pkg::AGU_OP_TABLE_REF) begin
                    state_nxt = agu_pkg::AGU_TREAD;
                end
            end
            agu_pkg::AGU_TREAD: begin
                state_nxt = agu_pkg::AGU_IDLE;
            end
            default: begin
                state_nxt = agu_pkg::AGU_IDLE;
            end
        endcase
    end

    // sequencer state register
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            state_r <= agu_pkg::AGU_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // table read request, addressed as in table jumping
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            tableAddr_r <= '0;
            tableRead_r <= 1'b0;
        end else begin
            tableRead_r <= stepFire && (stepOp == agu_pkg::AGU_OP_TABLE_REF);
            if (stepFire && stepOp == agu_pkg::AGU_OP_TABLE_REF) begin
                tableAddr_r <= tableTarget; // RL12
            end
        end
    end

    // destination latches; the word is ten bits wide throughout
    agu_table_ref #(
        .WORD_W(WORD_W)
    ) u_tref (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .capture(state_r == agu_pkg::AGU_TREAD && tableRead_r), // RL1
        .romWord(tableData),
        .accOut(accOut),
        .bOut(bOut),
        .accLoad(accLoad),
        .portOne(portLatchOne),
        .portTwo(portLatchTwo),
        .portLoad(portLoad)
    );

    // bank register write
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            bank_r <= `AGU_RST_BANK;
        end else if (regWr && regAddr == `AGU_OFF_BANK) begin
            bank_r <= regWrData; // RL3
        end
    end

    // read mux, data valid the cycle after the strobe; unmapped reads zero
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            rdData_r <= 4'h0;
        end else if (regRd) begin
            case (regAddr)
                `AGU_OFF_BANK: begin
                    rdData_r <= bank_r;
                end
                `AGU_OFF_PC0: begin
                    rdData_r <= pc_r[3:0];
                end
                `AGU_OFF_PC1: begin
                    rdData_r <= pc_r[7:4];
                end
                `AGU_OFF_PC2: begin
                    rdData_r <= pc_r[11:8];
                end
                `AGU_OFF_PC3: begin
                    rdData_r <= {2'b00, pc_r[13:12]};
                end
                `AGU_OFF_PORT1: begin
                    rdData_r <= portLatchOne;
                end
                `AGU_OFF_PORT2: begin
                    rdData_r <= portLatchTwo;
                end
                `AGU_OFF_STAT: begin
                    // busy while table data is awaited
                    rdData_r <= {3'b000, state_r == agu_pkg::AGU_TREAD};
                end
                default: begin
                    rdData_r <= 4'h0;
                end
            endcase
        end else begin
            // data stands only in the cycle after the read strobe
            rdData_r <= 4'h0;
        end
    end

    // outputs
    assign programCounter = pc_r;
    assign returnAddr = retAddr_r;
    assign callPush = callPush_r;
    assign ramAddr = ramAddr_r;
    assign ramBank = ramBank_r;
    assign ramStrobe = ramStrobe_r;
    assign ramSwap = ramSwap_r;
    assign tableAddr = tableAddr_r;
    assign tableRead = tableRead_r;
    assign regRdData = rdData_r;

endmodule

`default_nettype wire

//--- core/agu_params.svh
// Purpose: constants of the address generation unit
// Assumes: 4-bit data path, 10-bit ROM words, 14-bit program counter
// Notes: offsets are register-port addresses
// Function
// [RL1] ROM words are ten bits wide
// [RL2] indirect address is word, column, row concatenated
// [RL3] region 090-25F uses the bank register
// [RL4] direct RAM address comes from second word
// [RL5] scratch registers live at 040-04F
// [RL6] long jumps load all fourteen counter bits
// [RL7] 64 pages of 256 words
// [RL8] in-page jump replaces low eight bits
// [RL9] page-end jump lands in next page
// [RL10] zero-page call clears upper eight bits
// [RL11] table jump uses immediate, accumulator, B
// [RL12] table-reference bit 8 loads accumulator and B
// [RL13] bit 9 loads both port latches
// [RL14] table-reference advances counter normally only
// [RL15] counter advances per word across pages
`ifndef AGU_PARAMS_SVH
`define AGU_PARAMS_SVH

// register port offsets
`define AGU_OFF_BANK 10'h03F
`define AGU_OFF_PC0 10'h3F0
`define AGU_OFF_PC1 10'h3F1
`define AGU_OFF_PC2 10'h3F2
`define AGU_OFF_PC3 10'h3F3
`define AGU_OFF_PORT1 10'h3F5
`define AGU_OFF_PORT2 10'h3F6
`define AGU_OFF_STAT 10'h3F7

// reset values
`define AGU_RST_BANK 4'h0
`define AGU_RST_PC 14'h0000

// banked RAM window and scratch area
`define AGU_BANK_LO 10'h090
`define AGU_BANK_HI 10'h25F
`define AGU_SCR_BASE 6'h04

// field positions of a referenced ROM word
`define AGU_TREF_ACC_BIT 8
`define AGU_TREF_PORT_BIT 9

// ROM geometry
`define AGU_PAGE_BITS 8
`define AGU_PAGES 64

`endif

//--- core/agu_pkg.sv
// Purpose: types of the address generation unit
// Assumes: used with agu_params.svh
// Notes: operation classes come from the core's opcode decoder
package agu_pkg;

    // operation class of the instruction being executed
    typedef enum logic [3:0] {
        AGU_OP_SEQ,
        AGU_OP_LONG_JUMP,
        AGU_OP_LONG_BRANCH,
        AGU_OP_CALL,
        AGU_OP_IN_PAGE,
        AGU_OP_ZERO_CALL,
        AGU_OP_TABLE_JUMP,
        AGU_OP_TABLE_REF,
        AGU_OP_RAM_IND,
        AGU_OP_RAM_DIR,
        AGU_OP_SCR_LOAD,
        AGU_OP_SCR_SWAP
    } agu_op_t;

    // sequencer state
    typedef enum logic [0:0] {
        AGU_IDLE,
        AGU_TREAD
    } agu_state_t;

endpackage

//--- core/agu_table_ref.sv
// Purpose: destination latches of the table-reference instruction
// Assumes: romWord is valid in the cycle that capture is high
// Notes: both destinations may load in one operation
`include "agu_params.svh"
`timescale 1ns/1ps
`default_nettype none

module agu_table_ref #(
    parameter int WORD_W = 10
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_b,
    // ROM data
    input wire logic capture,
    input wire logic [WORD_W-1:0] romWord,
    // accumulator and B destination
    output logic [3:0] accOut,
    output logic [3:0] bOut,
    output logic accLoad,
    // port latches
    output logic [3:0] portOne,
    output logic [3:0] portTwo,
    output logic portLoad
);

    // flag bits of the referenced word
    logic toAcc;
    logic toPort;

    assign toAcc = romWord[`AGU_TREF_ACC_BIT];
    assign toPort = romWord[`AGU_TREF_PORT_BIT];

    // accumulator and B copy, with a one-cycle load pulse for the core
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            accOut <= 4'h0;
            bOut <= 4'h0;
            accLoad <= 1'b0;
        end else begin
            accLoad <= capture && toAcc; // RL12
            if (capture && toAcc) begin
                // low nibble to B, next nibble to the accumulator
                bOut <= romWord[3:0]; // RL12
                accOut <= romWord[7:4]; // RL12
            end
        end
    end

    // port output latches hold their value until the next load
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            portOne <= 4'h0;
            portTwo <= 4'h0;
            portLoad <= 1'b0;
        end else begin
            portLoad <= capture && toPort; // RL13
            if (capture && toPort) begin
                // independent of toAcc, so both may load together
                portOne <= romWord[3:0]; // RL13
                portTwo <= romWord[7:4]; // RL13
            end
        end
    end

endmodule

`default_nettype wire

//--- tb/agu_checker.sv
// Purpose: port-level checks of the address generation unit
// Assumes: bound to agu_top, one clock domain
// Notes: bank value is shadowed from register writes
`include "agu_params.svh"
`timescale 1ns/1ps
`default_nettype none
module agu_checker #(
    parameter int WORD_W = 10,
    parameter int PC_W = 14,
    parameter int RAM_W = 10
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_b,
    // step port
    input wire logic stepValid,
    input wire logic stepReady,
    input wire agu_pkg::agu_op_t stepOp,
    input wire logic [WORD_W-1:0] stepWordOne,
    input wire logic [WORD_W-1:0] stepWordTwo,
    input wire logic [3:0] accIn,
    input wire logic [3:0] bIn,
    input wire logic [1:0] wordIdx,
    input wire logic [3:0] colIdx,
    input wire logic [3:0] rowIdx,
    // results
    input wire logic [PC_W-1:0] programCounter,
    input wire logic callPush,
    input wire logic [RAM_W-1:0] ramAddr,
    input wire logic [3:0] ramBank,
    input wire logic ramStrobe,
    input wire logic ramSwap,
    input wire logic [PC_W-1:0] tableAddr,
    input wire logic tableRead,
    input wire logic [WORD_W-1:0] tableData,
    input wire logic [3:0] accOut,
    input wire logic [3:0] bOut,
    input wire logic accLoad,
    input wire logic [3:0] portLatchOne,
    input wire logic [3:0] portLatchTwo,
    input wire logic portLoad,
    // register port
    input wire logic [RAM_W-1:0] regAddr,
    input wire logic [3:0] regWrData,
    input wire logic regWr
);
    logic take; // step accepted at this edge
    logic [PC_W-1:0] pcInc; // sequential successor
    logic [3:0] shadowBank_r; // copy of the bank register
    assign take = stepValid && stepReady;
    assign pcInc = programCounter + 1'b1;
    // shadow the bank register so the window check needs no internal probe
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            shadowBank_r <= 4'h0;
        end else if (regWr && regAddr == `AGU_OFF_BANK) begin
            shadowBank_r <= regWrData;
        end
    end
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    a_long_load: assert property (take && stepOp inside {agu_pkg::AGU_OP_LONG_JUMP,
        agu_pkg::AGU_OP_LONG_BRANCH, agu_pkg::AGU_OP_CALL}
        |=> programCounter == {$past(stepWordOne[3:0]), $past(stepWordTwo)}) else $error("long");
    a_page_jump: assert property (take && stepOp == agu_pkg::AGU_OP_IN_PAGE
        |=> programCounter == {$past(pcInc[13:8]), $past(stepWordOne[7:0])}) else $error("page");
    a_zero_call: assert property (take && stepOp == agu_pkg::AGU_OP_ZERO_CALL
        |=> callPush && programCounter == {8'h00, $past(stepWordOne[5:0])}) else $error("zero");
    a_table_jump: assert property (take && stepOp == agu_pkg::AGU_OP_TABLE_JUMP
        |=> programCounter == {2'b00, $past(stepWordOne[3:0]), $past(accIn), $past(bIn)})
        else $error("table jump");
    a_seq_advance: assert property (take && stepOp inside {agu_pkg::AGU_OP_SEQ,
        agu_pkg::AGU_OP_RAM_IND} |=> programCounter == $past(pcInc)) else $error("advance");
    a_tref_read: assert property (take && stepOp == agu_pkg::AGU_OP_TABLE_REF
        |=> tableRead && !stepReady && programCounter == $past(pcInc)
        && tableAddr == {2'b00, $past(stepWordOne[3:0]), $past(accIn), $past(bIn)}
        ##1 stepReady && $stable(programCounter)) else $error("table read");
    a_acc_dest: assert property (tableRead |=> accLoad == $past(tableData[8])
        && (!accLoad || {accOut, bOut} == $past(tableData[7:0]))) else $error("acc dest");
    a_port_dest: assert property (tableRead |=> portLoad == $past(tableData[9])
        && (!portLoad || {portLatchTwo, portLatchOne} == $past(tableData[7:0])))
        else $error("port dest");
    a_indirect_addr: assert property (take && stepOp == agu_pkg::AGU_OP_RAM_IND
        |=> ramStrobe && ramAddr == {$past(wordIdx), $past(colIdx), $past(rowIdx)})
        else $error("indirect");
    a_direct_addr: assert property (take && stepOp == agu_pkg::AGU_OP_RAM_DIR
        |=> ramAddr == $past(stepWordTwo) && programCounter == $past(pcInc) + 1'b1)
        else $error("direct");
    a_scratch_addr: assert property (take && stepOp inside {agu_pkg::AGU_OP_SCR_LOAD,
        agu_pkg::AGU_OP_SCR_SWAP} |=> ramAddr == {6'h04, $past(stepWordOne[3:0])}
        && ramSwap == $past(stepOp == agu_pkg::AGU_OP_SCR_SWAP)) else $error("scratch");
    a_bank_window: assert property (ramStrobe |-> ramBank ==
        ((ramAddr >= 10'h090 && ramAddr <= 10'h25F) ? shadowBank_r : 4'h0)) else $error("bank");
    c_both_dest: cover property (accLoad && portLoad);
    c_page_end: cover property (take && stepOp == agu_pkg::AGU_OP_IN_PAGE && pcInc[7:0] == 8'h00);
    c_banked: cover property (ramStrobe && ramBank != 4'h0);
endmodule
`default_nettype wire

//--- tb/agu_table_rom.sv
// Purpose: program ROM model answering table reads
// Assumes: data needed in the cycle tableRead is high
// Notes: outside reads the bus flips every cycle
`timescale 1ns/1ps
`default_nettype none
module agu_table_rom #(
    parameter int WORD_W = 10,
    parameter int PC_W = 14
) (
    // clock
    input wire logic core_clk,
    // read port
    input wire logic [PC_W-1:0] tableAddr,
    input wire logic tableRead,
    output logic [WORD_W-1:0] tableData
);
    logic [WORD_W-1:0] held_r; // last bus value
    // ten-bit words; flag bits follow address bits 11:10
    assign tableData = tableRead ? {tableAddr[11:10], tableAddr[7:0] ^ 8'hA5} : ~held_r;
    always_ff @(posedge core_clk) begin
        held_r <= tableData;
    end
endmodule
`default_nettype wire

//--- tb/cpu_address_generation_bench.sv
// Purpose: directed bench of the address generation unit
// Assumes: calls start just after a clock edge
// Notes: step holds stepValid until the next call or idle
`include "agu_params.svh"
`timescale 1ns/1ps
`default_nettype none
module cpu_address_generation_bench;
    logic core_clk = 1'b0, rst_b = 1'b0, stepValid = 1'b0, regWr = 1'b0, regRd = 1'b0;
    agu_pkg::agu_op_t stepOp = agu_pkg::AGU_OP_SEQ;
    logic [9:0] stepWordOne = '0, stepWordTwo = '0, regAddr = '0, tableData, ramAddr;
    logic [3:0] accIn = '0, bIn = '0, colIdx = '0, rowIdx = '0, regWrData = '0;
    logic [1:0] wordIdx = '0;
    logic stepReady, callPush, ramStrobe, ramSwap, tableRead, accLoad, portLoad;
    logic [13:0] programCounter, tableAddr, returnAddr, pe;
    logic [3:0] ramBank, accOut, bOut, portLatchOne, portLatchTwo, regRdData, rd;
    logic [9:0] w;
    int failures = 0, compares = 0;
    always #2 core_clk = ~core_clk;
    agu_top u_agu_top (.core_clk, .rst_b, .stepValid, .stepReady, .stepOp, .stepWordOne,
        .stepWordTwo, .accIn, .bIn, .wordIdx, .colIdx, .rowIdx, .programCounter,
        .returnAddr, .callPush, .ramAddr, .ramBank, .ramStrobe, .ramSwap, .tableAddr,
        .tableRead, .tableData, .accOut, .bOut, .accLoad, .portLatchOne, .portLatchTwo,
        .portLoad, .regAddr, .regWrData, .regWr, .regRd, .regRdData);
    agu_table_rom u_agu_table_rom (.core_clk, .tableAddr, .tableRead, .tableData);
    task automatic chk(input string what, input logic [15:0] seen, exp);
        compares++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic print_verdict;
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // present one step and return just after the edge that takes it
    task automatic step(input agu_pkg::agu_op_t op, input logic [9:0] w1, w2);
        int n;
        n = 0;
        stepOp <= op;
        stepWordOne <= w1;
        stepWordTwo <= w2;
        stepValid <= 1'b1;
        #1;
        while (stepReady !== 1'b1 && n < 20) begin
            @(posedge core_clk);
            #1;
            n++;
        end
        // a stall that never ends counts against the run
        if (n == 20) failures++;
        @(posedge core_clk);
        #1;
    endtask
    task automatic idle;
        stepValid <= 1'b0;
        @(posedge core_clk);
        #1;
    endtask
    // trailing edge keeps two strobes from being set in one time step
    task automatic regWrite(input logic [9:0] a, input logic [3:0] d);
        regAddr <= a;
        regWrData <= d;
        regWr <= 1'b1;
        @(posedge core_clk);
        #1;
        regWr <= 1'b0;
        @(posedge core_clk);
        #1;
    endtask
    task automatic rdChk(input string what, input logic [9:0] a, input logic [3:0] exp);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge core_clk);
        #1;
        regRd <= 1'b0;
        chk(what, regRdData, exp);
        @(posedge core_clk);
        #1;
    endtask
    // a hang past some eighty times the expected run is cut short
    initial begin
        #20000;
        failures++;
        print_verdict();
    end
    initial begin
        repeat (10) @(posedge core_clk);
        rst_b <= 1'b1;
        @(posedge core_clk);
        #1;
        rdChk("bank reset", `AGU_OFF_BANK, 4'h0);
        regWrite(`AGU_OFF_BANK, 4'h5);
        rdChk("bank", `AGU_OFF_BANK, 4'h5);
        regWrite(10'h100, 4'hF);
        rdChk("unmapped", 10'h100, 4'h0);
        $display("test registers done");
        step(agu_pkg::AGU_OP_SEQ, 10'h000, 10'h000);
        chk("pc seq", programCounter, 14'h0001);
        step(agu_pkg::AGU_OP_RAM_DIR, 10'h000, 10'h2A5);
        chk("pc dir", programCounter, 14'h0003);
        chk("ram dir", ramAddr, 10'h2A5);
        step(agu_pkg::AGU_OP_LONG_JUMP, 10'h003, 10'h3C7);
        chk("long jump", programCounter, 14'h0FC7);
        step(agu_pkg::AGU_OP_LONG_BRANCH, 10'h001, 10'h0FF);
        chk("long branch", programCounter, 14'h04FF);
        step(agu_pkg::AGU_OP_CALL, 10'h000, 10'h0FF);
        chk("call", programCounter, 14'h00FF);
        chk("push", callPush, 1'b1);
        chk("return", returnAddr, 14'h0501);
        step(agu_pkg::AGU_OP_IN_PAGE, 10'h012, 10'h000);
        chk("page end", programCounter, 14'h0112);
        step(agu_pkg::AGU_OP_IN_PAGE, 10'h034, 10'h000);
        chk("in page", programCounter, 14'h0134);
        step(agu_pkg::AGU_OP_LONG_JUMP, 10'h000, 10'h1FF);
        step(agu_pkg::AGU_OP_SEQ, 10'h000, 10'h000);
        chk("page carry", programCounter, 14'h0200);
        step(agu_pkg::AGU_OP_ZERO_CALL, 10'h3FF, 10'h000);
        chk("zero call", programCounter, 14'h003F);
        chk("zero return", returnAddr, 14'h0201);
        accIn <= 4'h3;
        bIn <= 4'hC;
        step(agu_pkg::AGU_OP_TABLE_JUMP, 10'h005, 10'h000);
        chk("table jump", programCounter, 14'h053C);
        $display("test branches done");
        pe = 14'h053C;
        // every combination of the two destination flags, back to back
        for (int k = 0; k < 4; k++) begin
            w = {6'h00, k[1:0], 2'b01};
            accIn <= k[3:0];
            bIn <= 4'h9;
            pe = pe + 1'b1;
            step(agu_pkg::AGU_OP_TABLE_REF, w, 10'h000);
            chk("tref addr", tableAddr, {4'h0, k[1:0], 2'b01, k[3:0], 4'h9});
            chk("tref stall", {tableRead, stepReady}, 2'b10);
            chk("tref pc", programCounter, pe);
            @(posedge core_clk);
            #1;
            chk("acc load", accLoad, k[0]);
            chk("port load", portLoad, k[1]);
            if (k[0]) chk("acc b", {accOut, bOut}, {k[3:0], 4'h9} ^ 8'hA5);
            if (k[1]) chk("ports", {portLatchTwo, portLatchOne}, {k[3:0], 4'h9} ^ 8'hA5);
        end
        $display("test table reference done");
        wordIdx <= 2'h2;
        colIdx <= 4'h5;
        rowIdx <= 4'hA;
        step(agu_pkg::AGU_OP_RAM_IND, 10'h000, 10'h000);
        chk("indirect", {ramBank, ramAddr}, {4'h5, 10'h25A});
        wordIdx <= 2'h0;
        colIdx <= 4'h4;
        step(agu_pkg::AGU_OP_RAM_IND, 10'h000, 10'h000);
        chk("unbanked", {ramBank, ramAddr}, {4'h0, 10'h04A});
        step(agu_pkg::AGU_OP_SCR_LOAD, 10'h007, 10'h000);
        chk("scratch", ramAddr, 10'h047);
        step(agu_pkg::AGU_OP_SCR_SWAP, 10'h00E, 10'h000);
        chk("swap", {ramSwap, ramAddr}, {1'b1, 10'h04E});
        idle();
        rdChk("pc nib0", `AGU_OFF_PC0, 4'h4);
        rdChk("pc nib1", `AGU_OFF_PC1, 4'h4);
        rdChk("pc nib2", `AGU_OFF_PC2, 4'h5);
        rdChk("pc nib3", `AGU_OFF_PC3, 4'h0);
        rdChk("port one", `AGU_OFF_PORT1, 4'hC);
        rdChk("port two", `AGU_OFF_PORT2, 4'h9);
        rdChk("status", `AGU_OFF_STAT, 4'h0);
        $display("test ram addressing done");
        print_verdict();
    end
endmodule
bind agu_top agu_checker #(.WORD_W(WORD_W), .PC_W(PC_W), .RAM_W(RAM_W)) u_agu_checker (
    .core_clk, .rst_b, .stepValid, .stepReady, .stepOp, .stepWordOne, .stepWordTwo, .accIn,
    .bIn, .wordIdx, .colIdx, .rowIdx, .programCounter, .callPush, .ramAddr, .ramBank,
    .ramStrobe, .ramSwap, .tableAddr, .tableRead, .tableData, .accOut, .bOut, .accLoad,
    .portLatchOne, .portLatchTwo, .portLoad, .regAddr, .regWrData, .regWr);
`default_nettype wire
